// File: design/pwm_saw_pkg.sv
// Constants, register map and field layout of the sawtooth PWM generator
package pwm_saw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB slave
   localparam logic [7:0] OFS_TIMER_CTRL   = 8'h00;  // timer_control_a
   localparam logic [7:0] OFS_UNIT_MODE    = 8'h04;  // unit_mode_reg
   localparam logic [7:0] OFS_PERIOD_CMP   = 8'h08;  // period_compare
   localparam logic [7:0] OFS_PERIOD_BUF   = 8'h0C;  // period_buffer
   localparam logic [7:0] OFS_DUTY_CMP0    = 8'h10;  // duty_compare, phase 0 (phase n at +4n)
   localparam logic [7:0] OFS_DUTY_BUF0    = 8'h1C;  // duty_buffer, phase 0 (phase n at +4n)
   localparam logic [7:0] OFS_DEAD_TIME    = 8'h28;  // dead_time_value
   localparam logic [7:0] OFS_COUNTER      = 8'h2C;  // pwm_counter, read only
   localparam logic [7:0] OFS_STATUS       = 8'h30;  // live status, read only
   localparam logic [7:0] OFS_STRIDE       = 8'h04;  // Distance between phase registers

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in timer_control_a
   localparam int CTRL_RUN_BIT     = 0;   // count_run
   localparam int CTRL_DTE_BIT     = 1;   // dead_time_enable
   localparam int CTRL_PBX_BIT     = 2;   // period_buffer_xfer_en
   localparam int CTRL_DDW_BIT     = 3;   // duty_direct_write_en
   localparam int CTRL_CKS_LSB     = 4;   // count_clock_select, 3 bits
   localparam int CTRL_OE_BIT      = 7;   // port_function_ctrl: outputs in control mode
   localparam int CTRL_W           = 8;   // Implemented width

   // Field positions in unit_mode_reg
   localparam int MODE_SEL_LSB     = 0;   // pwm_mode_select, 2 bits
   localparam int MODE_POL_BIT     = 4;   // output_polarity, 1 = active high
   localparam int MODE_W           = 5;   // Implemented width

   // Field positions in the status word
   localparam int STAT_FF_LSB      = 0;   // Phase flip-flops
   localparam int STAT_FIRST_BIT   = 3;   // Counter in its first cycle
   localparam int STAT_BUSY_LSB    = 4;   // Dead-time counters running
   localparam int STAT_UP_BIT      = 7;   // Counting direction

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and fixed codes
   localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RST   = 5'h00;   // Sawtooth, active low
   localparam logic [15:0]       PERIOD_RST = 16'hFFFF;
   localparam logic [15:0]       DUTY_RST   = 16'h0000;
   localparam logic [9:0]        DT_RST     = 10'h000;
   localparam logic [9:0]        DT_IDLE    = 10'h3FF;  // Dead-time counter stopped
   localparam logic [1:0]        MODE_SAW   = 2'h0;     // Sawtooth (toothed wave)
   localparam logic [1:0]        MODE_TRI   = 2'h1;     // Asymmetric triangular

   // Counter run state, Gray coded along idle, first cycle, running
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FIRST = 2'b01,
      ST_RUN   = 2'b11
   } run_state_e;

endpackage : pwm_saw_pkg

// File: design/sawtooth_pwm_dead_time.sv
// Three-phase complementary PWM generator with dead time and APB registers
`timescale 1ns/1ps

// Summary of operation
// - Counter counts up, period match clears, pulses irq
// - Period lasts period compare plus one ticks
// - Transfer disabled: period buffer never copied
// - Transfer enabled: buffer copied on period match
// - Duty buffers copied on every period match
// - Direct duty writes only when enabled
// - Period match sets each phase flip-flop
// - Duty match resets that phase flip-flop
// - Each flip-flop change loads dead-time counter
// - Dead-time counts to zero, all-ones, stops
// - Dead time lasts value plus one clocks
// - Active widths follow duty, period, dead time
// - Too-short active width gives no pulse
// - Dead time only while its enable set
// - Count run starts counter and outputs
// - Before start positive inactive, negative active
// - Polarity bit inverts levels, default active low
// - Flip-flops frozen during first counter cycle
// - Duty above period: never reset, stays active
// - Triangle: duty equal period matches counting down
module sawtooth_pwm_dead_time #(
   parameter int CNT_W  = 16,   // Counter and compare width
   parameter int DT_W   = 10,   // Dead-time counter width
   parameter int PHASES = 3     // Number of complementary phase pairs
) (
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic      [2*PHASES-1:0] phaseOutputs,
   output logic      [2*PHASES-1:0] phaseOe,
   output logic                    periodMatchIrq
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   generate
      if (CNT_W != 16 || DT_W != 10 || PHASES < 1 || PHASES > 3) begin : g_badParam
         $error("sawtooth_pwm_dead_time: CNT_W must be 16, DT_W 10, PHASES 1 to 3");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Decode helper: address hit for a phase register
   function automatic logic phaseHit(input logic [7:0] addr, input logic [7:0] base, input int idx);
      logic [7:0] target;
      target = 8'(base + 8'(idx) * pwm_saw_pkg::OFS_STRIDE);
      return (addr == target);
   endfunction : phaseHit

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [pwm_saw_pkg::CTRL_W-1:0] timerCtrl_r;          // timer_control_a
   logic [pwm_saw_pkg::MODE_W-1:0] unitMode_r;           // unit_mode_reg
   logic [CNT_W-1:0]               periodCompare_r;      // Active period
   logic [CNT_W-1:0]               periodBuffer_r;       // Next period
   logic [CNT_W-1:0]               dutyCompare_r [PHASES]; // Active reset points
   logic [CNT_W-1:0]               dutyBuffer_r  [PHASES]; // Next reset points
   logic [DT_W-1:0]                deadTimeValue_r;      // Dead-time reload value
   logic [31:0]                    rdData_r;             // Captured read word
   logic                           slvErr_r;             // Captured unmapped flag

   // Counter state
   logic [CNT_W-1:0]               pwmCounter_r;         // Main counter
   logic [7:0]                     prescale_r;           // Count clock divider
   logic                           dirUp_r;              // Counting up
   pwm_saw_pkg::run_state_e        runState_r;           // Idle, first cycle, run
   logic                           irq_r;                // Registered match pulse

   // Per-phase state
   logic [PHASES-1:0]              phaseFf_r;            // 1 = positive phase active
   logic [DT_W-1:0]                deadTimeCounters_r [PHASES];
   logic [2*PHASES-1:0]            pinLevel_r;           // Registered pin levels

   ////////////////////////////////////////////////////////////////////////////
   // Control field taps
   wire              countRun      = timerCtrl_r[pwm_saw_pkg::CTRL_RUN_BIT];
   wire              deadTimeEn    = timerCtrl_r[pwm_saw_pkg::CTRL_DTE_BIT];
   wire              periodXferEn  = timerCtrl_r[pwm_saw_pkg::CTRL_PBX_BIT];
   wire              dutyDirectWe  = timerCtrl_r[pwm_saw_pkg::CTRL_DDW_BIT];
   wire [2:0]        countClockSel = timerCtrl_r[pwm_saw_pkg::CTRL_CKS_LSB +: 3];
   wire              controlMode   = timerCtrl_r[pwm_saw_pkg::CTRL_OE_BIT];
   wire [1:0]        pwmModeSel    = unitMode_r[pwm_saw_pkg::MODE_SEL_LSB +: 2];
   wire              outPolarity   = unitMode_r[pwm_saw_pkg::MODE_POL_BIT];
   wire              triMode       = (pwmModeSel == pwm_saw_pkg::MODE_TRI);

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire              accessPhase = psel & penable;
   wire              setupPhase  = psel & ~penable;
   wire              wrAccess    = accessPhase & pwrite;
   wire              selCtrl     = (paddr == pwm_saw_pkg::OFS_TIMER_CTRL);
   wire              selMode     = (paddr == pwm_saw_pkg::OFS_UNIT_MODE);
   wire              selPerCmp   = (paddr == pwm_saw_pkg::OFS_PERIOD_CMP);
   wire              selPerBuf   = (paddr == pwm_saw_pkg::OFS_PERIOD_BUF);
   wire              selDead     = (paddr == pwm_saw_pkg::OFS_DEAD_TIME);
   wire              selCnt      = (paddr == pwm_saw_pkg::OFS_COUNTER);
   wire              selStat     = (paddr == pwm_saw_pkg::OFS_STATUS);
   wire [PHASES-1:0] selDutyCmp;                         // Per-phase compare select
   wire [PHASES-1:0] selDutyBuf;                         // Per-phase buffer select
   wire [31:0]       dutyRdChain [PHASES+1];             // Read mux chain
   wire [PHASES-1:0] dtBusy;                             // Dead-time counter running
   wire              anyDutySel  = |{selDutyCmp, selDutyBuf};
   wire              addrValid   = selCtrl | selMode | selPerCmp | selPerBuf | selDead
                                   | selCnt | selStat | anyDutySel;

   // Status word of live state
   wire [31:0]       statusWord  = 32'({dirUp_r, 3'(dtBusy), 1'(runState_r == pwm_saw_pkg::ST_FIRST),
                                        3'(phaseFf_r)});

   // Read selection of the fixed registers
   assign dutyRdChain[0] = selCtrl   ? 32'(timerCtrl_r) :
                           selMode   ? 32'(unitMode_r) :
                           selPerCmp ? 32'(periodCompare_r) :
                           selPerBuf ? 32'(periodBuffer_r) :
                           selDead   ? 32'(deadTimeValue_r) :
                           selCnt    ? 32'(pwmCounter_r) :
                           selStat   ? statusWord : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Counter clock prescaler: one tick every 2^select system clocks
   wire [7:0]        prescaleMask = ~(8'hFF << countClockSel);
   wire              running      = (runState_r != pwm_saw_pkg::ST_IDLE);
   wire              tick         = running & ((prescale_r & prescaleMask) == prescaleMask);
   wire [7:0]        prescaleNxt  = running ? 8'(prescale_r + 8'h01) : 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // Counter events
   wire              atPeriod   = (pwmCounter_r == periodCompare_r);
   wire              atZero     = (pwmCounter_r == '0);
   wire              periodHit  = tick & atPeriod & (dirUp_r | ~triMode);
   wire              zeroHit    = tick & triMode & ~dirUp_r & atZero;
   wire              reloadEv   = periodHit | zeroHit;
   wire              cycleEnd   = triMode ? zeroHit : periodHit;
   wire              phaseLive  = (runState_r == pwm_saw_pkg::ST_RUN);

   // Next counter value: sawtooth wraps to zero, triangle turns round
   wire [CNT_W-1:0]  cntUp      = CNT_W'(pwmCounter_r + 1'b1);
   wire [CNT_W-1:0]  cntDown    = CNT_W'(pwmCounter_r - 1'b1);
   wire              goDown     = triMode & (dirUp_r ? periodHit : ~zeroHit);
   wire [CNT_W-1:0]  cntStep    = (~triMode & periodHit) ? '0 : (goDown ? cntDown : cntUp);
   wire [CNT_W-1:0]  counterNxt = ~running ? '0 : (tick ? cntStep : pwmCounter_r);
   wire              dirUpNxt   = ~running | (triMode ? (dirUp_r ? ~periodHit : zeroHit) : 1'b1);

   // Period compare source: hardware reload, then software write
   wire              perCmpWr   = wrAccess & selPerCmp;
   wire [CNT_W-1:0]  periodCmpNxt = (reloadEv & periodXferEn) ? periodBuffer_r :
                                    perCmpWr ? pwdata[CNT_W-1:0] : periodCompare_r;

   ////////////////////////////////////////////////////////////////////////////
   // Run state: idle until count run, first cycle frozen, then running
   pwm_saw_pkg::run_state_e runStateNxt;
   always_comb begin
      runStateNxt = runState_r;
      case (runState_r)
         pwm_saw_pkg::ST_IDLE: begin
            if (countRun) runStateNxt = pwm_saw_pkg::ST_FIRST;
         end
         pwm_saw_pkg::ST_FIRST: begin
            if (!countRun) runStateNxt = pwm_saw_pkg::ST_IDLE;
            else if (cycleEnd) runStateNxt = pwm_saw_pkg::ST_RUN;
         end
         pwm_saw_pkg::ST_RUN: begin
            if (!countRun) runStateNxt = pwm_saw_pkg::ST_IDLE;
         end
         default: begin
            runStateNxt = pwm_saw_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-phase logic: compare, flip-flop, dead time, pin levels
   genvar gi;
   generate
      for (gi = 0; gi < PHASES; gi++) begin : g_phase
         // Register selects for this phase
         assign selDutyCmp[gi] = phaseHit(paddr, pwm_saw_pkg::OFS_DUTY_CMP0, gi);
         assign selDutyBuf[gi] = phaseHit(paddr, pwm_saw_pkg::OFS_DUTY_BUF0, gi);
         assign dutyRdChain[gi+1] = selDutyCmp[gi] ? 32'(dutyCompare_r[gi]) :
                                    selDutyBuf[gi] ? 32'(dutyBuffer_r[gi]) : dutyRdChain[gi];

         // Duty match; a value above the period never matches
         wire dutyHit   = tick & (pwmCounter_r == dutyCompare_r[gi]);
         // Triangle: equality at the top, or any match above zero on the way down, resets
         wire downMatch = dutyHit & (atPeriod | (~dirUp_r & ~atZero));
         wire upMatch   = dutyHit & ~downMatch;
         // Reset wins over a coincident set
         wire rstEv     = phaseLive & (triMode ? downMatch : dutyHit);
         wire setEv     = ~rstEv & (triMode ? (phaseLive & upMatch) : periodHit);
         wire ffNxt     = rstEv ? 1'b0 : (setEv ? 1'b1 : phaseFf_r[gi]);

         // Dead-time counter: reload only when the flip-flop changes, so a repeated set keeps the level
         wire [DT_W-1:0] dtCur = deadTimeCounters_r[gi];
         wire [DT_W-1:0] dtDec = (dtCur == pwm_saw_pkg::DT_IDLE) ? dtCur : DT_W'(dtCur - 1'b1);
         wire [DT_W-1:0] dtNxt = ~deadTimeEn ? pwm_saw_pkg::DT_IDLE :
                                 (ffNxt != phaseFf_r[gi]) ? deadTimeValue_r : dtDec;
         assign dtBusy[gi] = (dtCur != pwm_saw_pkg::DT_IDLE);

         // Active levels are held off while the dead time runs
         wire posActive = phaseFf_r[gi] & ~dtBusy[gi];
         wire negActive = ~phaseFf_r[gi] & ~dtBusy[gi];
         wire posPin    = outPolarity ? posActive : ~posActive;
         wire negPin    = outPolarity ? negActive : ~negActive;

         // Duty compare source: hardware reload first, then permitted write
         wire dutyWr    = wrAccess & selDutyCmp[gi] & dutyDirectWe;
         wire [CNT_W-1:0] dutyCmpNxt = reloadEv ? dutyBuffer_r[gi] :
                                       dutyWr ? pwdata[CNT_W-1:0] : dutyCompare_r[gi];
         wire [CNT_W-1:0] dutyBufNxt = (wrAccess & selDutyBuf[gi]) ? pwdata[CNT_W-1:0] : dutyBuffer_r[gi];

         // Phase flip-flop and dead-time counter
         always_ff @(posedge clk) begin
            if (!nrst) begin
               phaseFf_r[gi]          <= 1'b0;
               deadTimeCounters_r[gi] <= pwm_saw_pkg::DT_IDLE;
            end else begin
               phaseFf_r[gi]          <= ffNxt;
               deadTimeCounters_r[gi] <= dtNxt;
            end
         end

         // Duty compare and buffer registers
         always_ff @(posedge clk) begin
            if (!nrst) begin
               dutyCompare_r[gi] <= pwm_saw_pkg::DUTY_RST;
               dutyBuffer_r[gi]  <= pwm_saw_pkg::DUTY_RST;
            end else begin
               dutyCompare_r[gi] <= dutyCmpNxt;
               dutyBuffer_r[gi]  <= dutyBufNxt;
            end
         end

         // Registered pin levels: even index positive, odd index negative
         always_ff @(posedge clk) begin
            if (!nrst) begin
               pinLevel_r[2*gi]   <= 1'b1;
               pinLevel_r[2*gi+1] <= 1'b0;
            end else begin
               pinLevel_r[2*gi]   <= posPin;
               pinLevel_r[2*gi+1] <= negPin;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Control and mode registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         timerCtrl_r <= pwm_saw_pkg::CTRL_RST;
         unitMode_r  <= pwm_saw_pkg::MODE_RST;
      end else begin
         if (wrAccess & selCtrl) timerCtrl_r <= pwdata[pwm_saw_pkg::CTRL_W-1:0];
         if (wrAccess & selMode) unitMode_r  <= pwdata[pwm_saw_pkg::MODE_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Period compare, period buffer and dead-time value
   always_ff @(posedge clk) begin
      if (!nrst) begin
         periodCompare_r <= pwm_saw_pkg::PERIOD_RST;
         periodBuffer_r  <= pwm_saw_pkg::PERIOD_RST;
         deadTimeValue_r <= pwm_saw_pkg::DT_RST;
      end else begin
         periodCompare_r <= periodCmpNxt;
         if (wrAccess & selPerBuf) periodBuffer_r  <= pwdata[CNT_W-1:0];
         if (wrAccess & selDead)   deadTimeValue_r <= pwdata[DT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter, prescaler, direction, run state and match pulse
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pwmCounter_r <= '0;
         prescale_r   <= 8'h00;
         dirUp_r      <= 1'b1;
         runState_r   <= pwm_saw_pkg::ST_IDLE;
         irq_r        <= 1'b0;
      end else begin
         pwmCounter_r <= counterNxt;
         prescale_r   <= prescaleNxt;
         dirUp_r      <= dirUpNxt;
         runState_r   <= runStateNxt;
         irq_r        <= periodHit;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read capture in the setup cycle; answer in the access cycle
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdData_r <= 32'h0000_0000;
         slvErr_r <= 1'b0;
      end else if (setupPhase) begin
         rdData_r <= (pwrite | ~addrValid) ? 32'h0000_0000 : dutyRdChain[PHASES];
         slvErr_r <= ~addrValid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata         = rdData_r;
   assign pready         = accessPhase;
   assign pslverr        = accessPhase & slvErr_r;
   assign periodMatchIrq = irq_r;
   assign phaseOutputs   = pinLevel_r;
   assign phaseOe        = {(2*PHASES){controlMode}};

endmodule : sawtooth_pwm_dead_time

// File: test/sawtooth_pwm_dead_time_assertions.sv
// Port-level concurrent checks for the sawtooth PWM generator
`timescale 1ns/1ps
module sawtooth_pwm_dead_time_assertions #(
   parameter int DT_W   = 10,
   parameter int PHASES = 3
) (
   input wire logic                  clk,
   input wire logic                  nrst,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [7:0]            paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [2*PHASES-1:0]   phaseOutputs,
   input wire logic [2*PHASES-1:0]   phaseOe,
   input wire logic                  periodMatchIrq
);
   wire               wrStb = psel && penable && pwrite; // APB write completing
   logic              polR, polPrevR, runR, dteR, seenIrqR; // Shadows of control state
   logic [DT_W-1:0]   dtValR;                           // Programmed dead time
   logic [DT_W:0]     eqLenR;                           // Length of equal-level run, pair 0
   logic [PHASES-1:0] pairEq, pairOn;                   // Pair levels equal, pair both active
   // Per pair: equal levels, and equal at the active level
   always_comb begin
      for (int n = 0; n < PHASES; n++) begin
         pairEq[n] = phaseOutputs[2*n] == phaseOutputs[2*n+1];
         pairOn[n] = pairEq[n] && (phaseOutputs[2*n] == polPrevR);
      end
   end
   // Shadow registers follow APB writes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         {polR, polPrevR, runR, dteR, seenIrqR} <= '0;
         dtValR <= '0;
         eqLenR <= '0;
      end else begin
         polPrevR <= polR;
         seenIrqR <= seenIrqR || periodMatchIrq;
         eqLenR   <= pairEq[0] ? eqLenR + 1'b1 : '0;
         if (wrStb && paddr == pwm_saw_pkg::OFS_UNIT_MODE) polR <= pwdata[pwm_saw_pkg::MODE_POL_BIT];
         if (wrStb && paddr == pwm_saw_pkg::OFS_TIMER_CTRL) runR <= pwdata[pwm_saw_pkg::CTRL_RUN_BIT];
         if (wrStb && paddr == pwm_saw_pkg::OFS_TIMER_CTRL) dteR <= pwdata[pwm_saw_pkg::CTRL_DTE_BIT];
         if (wrStb && paddr == pwm_saw_pkg::OFS_DEAD_TIME) dtValR <= pwdata[DT_W-1:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_RESET_LEVELS:
   assert property (disable iff (1'b0) !nrst |=> phaseOutputs == {PHASES{2'b01}} && phaseOe == '0
      && !periodMatchIrq) else $error("outputs wrong after reset");
   AST_IRQ_PULSE:
   assert property (periodMatchIrq |=> !periodMatchIrq) else $error("match pulse longer than one cycle");
   AST_NO_OVERLAP:
   assert property (pairOn == '0) else $error("both outputs of a pair active");
   AST_DT_WIDTH:
   assert property ($fell(pairEq[0]) |-> eqLenR >= dtValR + 1'b1) else $error("dead time too short");
   AST_NO_DT_OFF:
   assert property (!dteR && !$past(dteR) && !$past(dteR, 2) |-> pairEq == '0) else $error("dead time while disabled");
   AST_IDLE_NO_IRQ:
   assert property (!runR && !$past(runR) && !$past(runR, 2) |-> !periodMatchIrq) else $error("match while stopped");
   AST_FROZEN_START:
   assert property (!seenIrqR && !periodMatchIrq |-> phaseOutputs == (polPrevR ? {PHASES{2'b10}}
      : {PHASES{2'b01}})) else $error("outputs moved before first match");
   AST_POL_INVERT:
   assert property (polR != polPrevR && !runR && !$past(runR) |=> phaseOutputs == ~$past(phaseOutputs))
      else $error("polarity change did not invert outputs");
endmodule : sawtooth_pwm_dead_time_assertions
bind sawtooth_pwm_dead_time sawtooth_pwm_dead_time_assertions #(.DT_W(DT_W), .PHASES(PHASES)) chk_i (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .phaseOutputs(phaseOutputs), .phaseOe(phaseOe),
   .periodMatchIrq(periodMatchIrq));

// File: test/inverter_stage_model.sv
// Behavioural inverter power stage driven by the six phase pins
`timescale 1ns/1ps
module inverter_stage_model (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic [5:0] phaseOutputs,
   input wire logic [5:0] phaseOe,
   input wire logic       activeHigh,   // Pin level that turns a switch on
   output logic     [2:0] upperOn,      // High-side switch of each leg conducting
   output logic     [2:0] lowerOn,      // Low-side switch of each leg conducting
   output logic           shoot         // Sticky: both switches of one leg conducted
);
   // A switch conducts only while its pin is driven at the active level
   always_comb begin
      for (int n = 0; n < 3; n++) begin
         upperOn[n] = phaseOe[2*n] && (phaseOutputs[2*n] == activeHigh);
         lowerOn[n] = phaseOe[2*n+1] && (phaseOutputs[2*n+1] == activeHigh);
      end
   end
   // Shoot-through would destroy the real stage; remember it
   always_ff @(posedge clk) begin
      if (!nrst) shoot <= 1'b0;
      else if (|(upperOn & lowerOn)) shoot <= 1'b1;
   end
endmodule : inverter_stage_model

// File: test/testbench.sv
// Self-checking bench for the sawtooth PWM generator
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
   logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, activeHigh = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, periodMatchIrq, shoot, err;
   logic [5:0]  phaseOutputs, phaseOe;
   logic [2:0]  upperOn, lowerOn;
   int          num_errors = 0, samples_checked = 0, gapLen, upC [3], loC [3];
   always #10 clk = ~clk;
   sawtooth_pwm_dead_time sawtooth_pwm_dead_time_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .phaseOutputs(phaseOutputs), .phaseOe(phaseOe), .periodMatchIrq(periodMatchIrq));
   inverter_stage_model inverter_stage_model_i (.clk(clk), .nrst(nrst), .phaseOutputs(phaseOutputs),
      .phaseOe(phaseOe), .activeHigh(activeHigh), .upperOn(upperOn), .lowerOn(lowerOn), .shoot(shoot));
   // Counts, verdict, end of run
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // One APB transfer; read data and error taken at the pready edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin num_errors++; conclude(); end
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : bus
   // Bounded wait for the period-match pulse
   task automatic waitIrq;
      int k;
      for (k = 0; k < 4000; k++) begin
         @(posedge clk);
         if (periodMatchIrq === 1'b1) break;
      end
      if (k == 4000) begin num_errors++; conclude(); end
   endtask : waitIrq
   // Clocks between two pulses
   task automatic gap;
      waitIrq();
      gapLen = 0;
      do begin @(posedge clk); gapLen++; end while (periodMatchIrq !== 1'b1 && gapLen < 4000);
   endtask : gap
   // Switch on-time per leg over one whole period of len clocks
   task automatic measure(input int len);
      upC = '{0, 0, 0};
      loC = '{0, 0, 0};
      repeat (len) begin
         @(posedge clk);
         for (int n = 0; n < 3; n++) begin upC[n] += upperOn[n]; loC[n] += lowerOn[n]; end
      end
   endtask : measure
   // Reset values and an unmapped access
   task automatic t_reset;
      bus(1'b0, pwm_saw_pkg::OFS_TIMER_CTRL, 32'h0); `CHK(rd, 32'h0)
      bus(1'b0, pwm_saw_pkg::OFS_PERIOD_BUF, 32'h0); `CHK(rd, 32'h0000FFFF)
      bus(1'b0, 8'h40, 32'h0); `CHK({err, rd}, 33'h100000000)
   endtask : t_reset
   // P=9, duties 4 / above period / 0, dead time 1, no period transfer
   task automatic t_sawtooth;
      bus(1'b1, pwm_saw_pkg::OFS_PERIOD_CMP, 32'h9);
      bus(1'b1, pwm_saw_pkg::OFS_PERIOD_BUF, 32'h4);
      bus(1'b1, pwm_saw_pkg::OFS_DUTY_BUF0, 32'h4);
      bus(1'b1, pwm_saw_pkg::OFS_DUTY_BUF0 + 8'h04, 32'hC);
      bus(1'b1, pwm_saw_pkg::OFS_DUTY_BUF0 + 8'h08, 32'h0);
      bus(1'b1, pwm_saw_pkg::OFS_DEAD_TIME, 32'h1);
      bus(1'b1, pwm_saw_pkg::OFS_TIMER_CTRL, 32'h83); // Control mode, dead time, run
      gap(); `CHK(gapLen, 10)
      measure(10);
      `CHK({upC[0], loC[0]}, {32'd3, 32'd3})
      `CHK({upC[1], loC[1]}, {32'd10, 32'd0})
      `CHK({upC[2], loC[2]}, {32'd0, 32'd7})
      `CHK(phaseOe, 6'h3F)
      bus(1'b0, pwm_saw_pkg::OFS_PERIOD_CMP, 32'h0); `CHK(rd, 32'h9)
   endtask : t_sawtooth
   // Blocked direct duty write, then period transfer enabled
   task automatic t_buffers;
      bus(1'b1, pwm_saw_pkg::OFS_DUTY_CMP0, 32'h7);
      bus(1'b0, pwm_saw_pkg::OFS_DUTY_CMP0, 32'h0); `CHK(rd, 32'h4)
      bus(1'b1, pwm_saw_pkg::OFS_TIMER_CTRL, 32'h87);
      gap();
      gap(); `CHK(gapLen, 5)
   endtask : t_buffers
   // Stop, direct duty write, active-high outputs, no dead time, frozen first cycle, restart
   task automatic t_polarity;
      bus(1'b1, pwm_saw_pkg::OFS_TIMER_CTRL, 32'h8A);
      bus(1'b1, pwm_saw_pkg::OFS_PERIOD_CMP, 32'h9);
      bus(1'b1, pwm_saw_pkg::OFS_DUTY_CMP0 + 8'h04, 32'h2);
      bus(1'b0, pwm_saw_pkg::OFS_DUTY_CMP0 + 8'h04, 32'h0); `CHK(rd, 32'h2)
      bus(1'b1, pwm_saw_pkg::OFS_UNIT_MODE, 32'h10);
      activeHigh <= 1'b1;
      bus(1'b1, pwm_saw_pkg::OFS_TIMER_CTRL, 32'h81);
      measure(10); `CHK(upC[1], 32'd10)
      waitIrq();
      measure(10);
      `CHK({upC[0], loC[0], loC[2]}, {32'd5, 32'd5, 32'd9})
      `CHK(shoot, 1'b0)
   endtask : t_polarity
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_sawtooth();
      t_buffers();
      t_polarity();
      conclude();
   end
endmodule : testbench
